// ---- shared/fetch_map_pkg.sv ----
/*
 * Constants for the instruction fetch and data map block: program counter
 * width, two-word instruction encodings, data bank geometry.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fetch_map_pkg;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OFFS_W = 8;
    localparam int NUM_BANKS = 16;
    localparam int BANK_BYTES = 256;
    localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
    // first-word opcode patterns, top bits of the word
    localparam logic [7:0] OP_CALL_HI = 8'hEC;
    localparam logic [7:0] OP_JUMP_HI = 8'hEF;
    localparam logic [3:0] OP_FAM_HI = 4'hC;
    localparam logic [7:0] OP_PLL_HI = 8'hEE;
    localparam logic [3:0] OP_BRA_HI = 4'hD;
    localparam logic [7:0] OP_BANK_LD_HI = 8'h01;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
    localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
    // access bank split: below goes to bank 0, at or above to bank 15
    localparam logic [OFFS_W-1:0] ACCESS_SPLIT = 8'h60;
    localparam int PHASES = 4;
endpackage : fetch_map_pkg

// ---- shared/fetch_data_if.sv ----
/*
 * Data memory access bundle between the decoder and the data map.
 * Assumes a single clock; both ends are design modules.
 */
`timescale 1ns/1ps
interface fetch_data_if;
    logic [7:0] offset;
    logic use_access;
    logic use_full;
    logic [11:0] full_addr;
    logic [3:0] bank;
    logic [11:0] addr;
    logic [7:0] rd_data;
    modport core
    (
        output offset, use_access, use_full, full_addr, bank,
        input addr, rd_data
    );
    modport map
    (
        input offset, use_access, use_full, full_addr, bank,
        output addr, rd_data
    );
endinterface : fetch_data_if

// ---- rtl/data_addr_map.sv ----
/*
 * Forms the 12-bit data address from bank pointer, access bank or a full
 * address, and masks read data from unimplemented locations to zero.
 * Assumes raw RAM read data arrives combinationally from the array.
 */
`timescale 1ns/1ps
module data_addr_map
    import fetch_map_pkg::*;
#(
    parameter int IMPL_BANKS = 16
)
(
    fetch_data_if.map dm,
    // ram side
    input wire logic [7:0] i_ram_rd_data,
    output logic o_implemented
);
    logic [DADDR_W-1:0] banked_addr;
    logic [DADDR_W-1:0] access_addr;
    logic [BANK_W-1:0] sel_bank;

    assign banked_addr = {dm.bank, dm.offset};
    // access bank lower gpr or top sfr
    assign access_addr = (dm.offset < ACCESS_SPLIT)
        ? {4'h0, dm.offset} : {4'hF, dm.offset};
    assign dm.addr = dm.use_full ? dm.full_addr
        : (dm.use_access ? access_addr : banked_addr);
    // upper nibble picks one of 16 banks
    assign sel_bank = dm.addr[DADDR_W-1:OFFS_W];
    // sfr bank is always present even in small parts
    assign o_implemented = (32'(sel_bank) < IMPL_BANKS)
        || (sel_bank == 4'hF);
    assign dm.rd_data = o_implemented ? i_ram_rd_data : 8'h00;
endmodule : data_addr_map

// ---- rtl/instr_fetch_core.sv ----
/*
 * Instruction fetch sequencer and data map front end: four-phase cycle,
 * even-aligned program counter, two-word instruction handling, relative
 * and absolute branches, bank pointer.
 * Assumes program memory answers a byte address within one phase and
 * data RAM reads combinationally; i_skip comes from same-clock logic.
 */
`timescale 1ns/1ps

module instr_fetch_core
    import fetch_map_pkg::*;
#(
    parameter int IMPL_BANKS = 16
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // program memory
    output logic [PC_W-1:0] o_prog_addr,
    input wire logic [7:0] i_prog_byte,
    // sequencing
    input wire logic i_skip,
    input wire logic i_bank_wr,
    input wire logic [7:0] i_bank_wr_data,
    // data memory
    input wire logic [7:0] i_ram_rd_data,
    output logic [DADDR_W-1:0] o_data_addr,
    output logic [7:0] o_data_rd,
    output logic o_data_implemented,
    // decode results
    output logic [15:0] o_instr,
    output logic [11:0] o_literal,
    output logic o_literal_valid,
    output logic o_exec_nop,
    output logic o_exec_strobe,
    output logic [7:0] o_bank_pointer,
    output logic [PC_W-1:0] o_pc
);
    typedef enum logic [3:0]
    {
        PH_1 = 4'b0001,
        PH_2 = 4'b0010,
        PH_3 = 4'b0100,
        PH_4 = 4'b1000
    } phase_t;

    phase_t phase;
    phase_t next_phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic [15:0] fetch_word;
    logic [15:0] ir;
    logic [15:0] first_word;
    logic pending_second;
    logic flush;
    logic [BANK_W-1:0] bank;
    logic [11:0] literal;
    logic literal_valid;
    logic exec_nop;
    logic [DADDR_W-1:0] data_addr;
    logic [7:0] data_rd;
    fetch_data_if dm();

    function automatic logic is_two_word(input logic [15:0] w);
        // call, jump, full move, pointer load
        return (w[15:8] == OP_CALL_HI) || (w[15:8] == OP_JUMP_HI)
            || (w[15:12] == OP_FAM_HI) || (w[15:8] == OP_PLL_HI);
    endfunction : is_two_word

    function automatic logic is_second(input logic [15:0] w);
        // tag nibble marks a second word
        return w[15:12] == SECOND_WORD_TAG;
    endfunction : is_second

    wire phase_end = (phase == PH_4);
    wire ir_second = is_second(ir);
    wire ir_two = is_two_word(ir);
    // second word consumed with its first
    wire consume = pending_second && ir_second;
    wire is_jump = consume && (first_word[15:8] == OP_JUMP_HI
        || first_word[15:8] == OP_CALL_HI);
    wire is_bra = !pending_second && (ir[15:12] == OP_BRA_HI);
    wire [19:0] abs_word = {ir[11:0], first_word[7:0]};
    wire [PC_W-1:0] bra_disp = PC_W'({{10{ir[10]}}, ir[10:0]});

    always_comb
    begin
        case (phase)
            PH_1: next_phase = PH_2;
            PH_2: next_phase = PH_3;
            PH_3: next_phase = PH_4;
            PH_4: next_phase = PH_1;
            default: next_phase = PH_1;
        endcase
    end

    always_comb
    begin
        // word steps keep bit zero clear
        next_pc = pc + PC_W'(2);
        if (is_jump)
            next_pc = {abs_word[PC_W-2:0], 1'b0};
        else if (is_bra)
            next_pc = pc + {bra_disp[PC_W-2:0], 1'b0};
    end

    // byte address, low then high byte
    assign o_prog_addr = (phase == PH_4) ? (pc | PC_W'(1)) : pc;

    // four-phase cycle from the one clock
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            phase <= PH_1;
        else
            phase <= next_phase;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            fetch_word <= 16'h0000;
        else if (phase == PH_3)
            fetch_word[7:0] <= i_prog_byte;
        else if (phase == PH_4)
            fetch_word[15:8] <= i_prog_byte;
    end

    // fetch of next overlaps execute of current
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pc <= PC_RESET;
            ir <= NOP_WORD;
            first_word <= NOP_WORD;
            pending_second <= 1'b0;
            flush <= 1'b0;
        end
        else if (phase_end)
        begin
            pc <= next_pc;
            // a taken change of flow discards the word in flight
            flush <= is_jump || is_bra || i_skip;
            // only the one word in flight is dropped, never the target
            ir <= (i_skip || is_jump || is_bra)
                ? NOP_WORD : {i_prog_byte, fetch_word[7:0]};
            // first word arms a second cycle
            pending_second <= ir_two && !pending_second && !flush;
            if (ir_two && !pending_second)
                first_word <= ir;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            bank <= BANK_RESET;
        else if (i_bank_wr)
            bank <= i_bank_wr_data[BANK_W-1:0];
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            literal <= 12'h000;
            literal_valid <= 1'b0;
            exec_nop <= 1'b0;
            data_rd <= 8'h00;
        end
        else
        begin
            if (phase == PH_1)
            begin
                literal <= ir[11:0];
                literal_valid <= consume;
                // lone tagged word is a no-op
                exec_nop <= (ir_second && !pending_second)
                    || (ir == NOP_WORD);
            end
            if (phase == PH_2)
                data_rd <= dm.rd_data;
        end
    end

    assign dm.offset = ir[7:0];
    // access bit clear selects the access bank
    assign dm.use_access = !ir[8];
    assign dm.use_full = pending_second && (first_word[15:12] == OP_FAM_HI);
    assign dm.full_addr = first_word[11:0];
    assign dm.bank = bank;

    data_addr_map #(
        .IMPL_BANKS(IMPL_BANKS)
    ) u_map (
        .dm(dm.map),
        .i_ram_rd_data(i_ram_rd_data),
        .o_implemented(o_data_implemented)
    );

    assign data_addr = dm.addr;
    assign o_data_addr = data_addr;
    assign o_data_rd = data_rd;
    assign o_instr = ir;
    assign o_literal = literal;
    assign o_literal_valid = literal_valid;
    assign o_exec_nop = exec_nop;
    assign o_exec_strobe = (phase == PH_1);
    assign o_bank_pointer = {4'h0, bank};
    assign o_pc = pc;
endmodule : instr_fetch_core

// ---- test/fetch_mem_model.sv ----
/* program bytes and data ram behind the fetch core.
   assumes the bench fills prog before releasing reset. */
`timescale 1ns/1ps
module fetch_mem_model
    import fetch_map_pkg::*;
(
    // fetch side
    input wire logic [PC_W-1:0] i_prog_addr,
    output logic [7:0] o_prog_byte,
    // data side
    input wire logic [DADDR_W-1:0] i_data_addr,
    output logic [7:0] o_ram_rd_data
);
    logic [7:0] prog [0:63];
    wire in_range = i_prog_addr < 21'h00_0040;
    assign o_prog_byte = in_range ? prog[i_prog_addr[5:0]] : 8'h00;
    // nonzero pattern so masking to zero shows
    assign o_ram_rd_data = i_data_addr[7:0] ^ 8'h5a;
endmodule : fetch_mem_model

// ---- test/fetch_core_props.sv ----
/* assertions on the fetch core pins.
   assumes binding to instr_fetch_core by name. */
`timescale 1ns/1ps
module fetch_core_props
    import fetch_map_pkg::*;
#(
    parameter int IMPL_BANKS = 16
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // watched pins
    input wire logic [PC_W-1:0] o_prog_addr,
    input wire logic i_bank_wr,
    input wire logic [7:0] i_bank_wr_data,
    input wire logic [DADDR_W-1:0] o_data_addr,
    input wire logic [7:0] o_data_rd,
    input wire logic o_data_implemented,
    input wire logic [15:0] o_instr,
    input wire logic o_exec_strobe,
    input wire logic [7:0] o_bank_pointer,
    input wire logic [PC_W-1:0] o_pc
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    wire [3:0] wr_nib = i_bank_wr_data[3:0];
    wire [3:0] bank_of = o_data_addr[11:8];
    wire bank_exists = (bank_of == 4'hf) || (int'(bank_of) < IMPL_BANKS);
    sequence quiet_phases;
        !o_exec_strobe [*3];
    endsequence
    sequence low_fetch;
        !o_prog_addr[0] [*3];
    endsequence
    sequence unimpl_cycle;
        o_exec_strobe && !o_data_implemented ##1 !o_data_implemented [*3];
    endsequence
    strobe_period_a: assert property (
        o_exec_strobe |=> quiet_phases ##1 o_exec_strobe)
        else $error("strobe not one in four");
    byte_order_a: assert property (
        o_exec_strobe |-> low_fetch ##1 o_prog_addr[0])
        else $error("fetch byte order wrong");
    addr_follow_a: assert property (
        o_prog_addr[PC_W-1:1] == o_pc[PC_W-1:1])
        else $error("fetch address off pc");
    ir_stand_a: assert property (
        o_exec_strobe |=> ($stable(o_pc) && $stable(o_instr) && !o_pc[0]) [*3])
        else $error("pc or ir moved mid cycle");
    bank_write_a: assert property (
        i_bank_wr |=> o_bank_pointer == {4'h0, $past(wr_nib)})
        else $error("bank pointer write wrong");
    bank_hold_a: assert property (
        !i_bank_wr |=> $stable(o_bank_pointer))
        else $error("bank pointer changed unasked");
    impl_map_a: assert property (
        o_data_implemented == bank_exists)
        else $error("implemented flag wrong");
    unimpl_zero_a: assert property (
        unimpl_cycle |=> o_data_rd == 8'h00)
        else $error("unimplemented read not zero");
endmodule : fetch_core_props

bind instr_fetch_core fetch_core_props #(.IMPL_BANKS(IMPL_BANKS)) u_props (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .o_prog_addr(o_prog_addr),
    .i_bank_wr(i_bank_wr), .i_bank_wr_data(i_bank_wr_data),
    .o_data_addr(o_data_addr), .o_data_rd(o_data_rd), .o_pc(o_pc),
    .o_data_implemented(o_data_implemented), .o_instr(o_instr),
    .o_exec_strobe(o_exec_strobe), .o_bank_pointer(o_bank_pointer));

// ---- test/instr_fetch_data_map_bench.sv ----
/* self-checking bench: fetch core, memory model, checker.
   assumes the model answers within the same clock. */
`timescale 1ns/1ps
module instr_fetch_data_map_bench
    import fetch_map_pkg::*;
;
    typedef struct {logic [15:0] w; logic nop; logic lv; logic [11:0] lit;
        logic [PC_W-1:0] pc; logic dck; logic im; logic [11:0] da;
        logic [7:0] rd;} exp_t;
    logic i_sys_clk = 0, i_reset_n = 0, i_skip = 0, i_bank_wr = 0;
    logic [7:0] i_bank_wr_data = 8'h00, pb, rd, o_data_rd, o_bank_pointer;
    logic [PC_W-1:0] pa, o_pc;
    logic [11:0] da, o_literal;
    logic [15:0] o_instr;
    logic impl, o_literal_valid, o_exec_nop, o_exec_strobe, pend = 0, go = 0;
    logic pend2 = 0;
    logic [7:0] pointer_literal_load = 8'h20;
    int fail_count = 0, n_tests = 0, t;
    exp_t exq [$];
    exp_t cur;
    always #20 i_sys_clk = ~i_sys_clk;
    instr_fetch_core #(.IMPL_BANKS(4)) u_instr_fetch_core (
        .i_sys_clk, .i_reset_n, .o_prog_addr(pa), .i_prog_byte(pb), .i_skip,
        .i_bank_wr, .i_bank_wr_data, .i_ram_rd_data(rd), .o_data_addr(da),
        .o_data_rd, .o_data_implemented(impl), .o_instr, .o_literal,
        .o_literal_valid, .o_exec_nop, .o_exec_strobe, .o_bank_pointer, .o_pc);
    fetch_mem_model u_fetch_mem_model (.i_prog_addr(pa), .o_prog_byte(pb),
        .i_data_addr(da), .o_ram_rd_data(rd));
    function automatic logic [7:0] pointer_literal_load_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : pointer_literal_load_next
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want)
        begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic chk_flag(input logic got, input logic want);
        n_tests++;
        if (got !== want)
        begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask : chk_flag
    // tags the last queued word with its data-side result
    task automatic expect_data(input logic [11:0] a, input logic [7:0] d,
        input logic im);
        exp_t e;
        e = exq.pop_back();
        e.dck = 1'b1;
        e.da = a;
        e.rd = d;
        e.im = im;
        exq.push_back(e);
    endtask : expect_data
    // flushed words execute as the zero word, pc unknown there
    task automatic step(input int a, input logic [15:0] w, input logic fl,
        input logic lv);
        exp_t e;
        u_fetch_mem_model.prog[a] = w[7:0];
        u_fetch_mem_model.prog[a + 1] = w[15:8];
        e.w = fl ? 16'h0000 : w;
        e.nop = fl || (w[15:12] == 4'hf && !lv);
        e.lv = lv;
        e.lit = w[11:0];
        e.pc = fl ? '0 : PC_W'(a + 2);
        e.dck = 1'b0;
        exq.push_back(e);
    endtask : step
    task test_done;
        $display("fail_count %0d n_tests %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    always @(negedge i_sys_clk)
    begin
        // read data lands at the phase-2 edge, so look one edge later
        if (pend2)
        begin
            if (cur.dck) chk(32'(o_data_rd), 32'(cur.rd));
            pend2 = 0;
        end
        if (pend)
        begin
            chk_flag(o_exec_nop, cur.nop);
            chk_flag(o_literal_valid, cur.lv);
            if (cur.lv) chk(32'(o_literal), 32'(cur.lit));
            pend = 0;
            pend2 = 1;
        end
        if (i_reset_n && o_exec_strobe && (go || o_instr !== 16'h0000)
            && exq.size() > 0)
        begin
            go = 1;
            cur = exq.pop_front();
            chk(32'(o_instr), 32'(cur.w));
            if (cur.pc !== '0) chk(32'(o_pc), 32'(cur.pc));
            if (cur.dck) chk(32'(da), 32'(cur.da));
            if (cur.dck) chk_flag(impl, cur.im);
            pend = 1;
        end
    end
    initial
    begin
        for (int i = 0; i < 64; i++) u_fetch_mem_model.prog[i] = 8'h00;
        step(0, 16'h0e95, 0, 0);
        expect_data(12'hf95, 8'hcf, 1);
        step(2, 16'hef05, 0, 0);
        step(4, 16'hf000, 0, 1);
        step(6, 16'h1234, 1, 0);
        step(10, 16'hc123, 0, 0);
        step(12, 16'hf456, 0, 1);
        expect_data(12'h123, 8'h79, 1);
        step(14, 16'hd001, 0, 0);
        step(16, 16'h5555, 1, 0);
        step(18, 16'hf789, 0, 0);
        step(20, 16'h6600, 0, 0);
        expect_data(12'h000, 8'h5a, 1);
        step(22, 16'hc111, 1, 0);
        step(24, 16'hf222, 0, 0);
        step(26, 16'h2500, 0, 0);
        expect_data(12'h600, 8'h00, 0);
        repeat (5) @(negedge i_sys_clk);
        i_reset_n = 1;
        for (int k = 0; k < 6; k++)
        begin
            pointer_literal_load = pointer_literal_load_next(pointer_literal_load);
            i_bank_wr_data = (k == 5) ? 8'h36 : pointer_literal_load;
            i_bank_wr = 1;
            @(negedge i_sys_clk);
            i_bank_wr = 0;
            @(negedge i_sys_clk);
            chk(32'(o_bank_pointer), {28'h0, i_bank_wr_data[3:0]});
        end
        for (t = 0; t < 200 && !(o_exec_strobe && o_instr === 16'h6600); t++)
            @(negedge i_sys_clk);
        if (t == 200) fail_count++;
        i_skip = 1;
        repeat (4) @(negedge i_sys_clk);
        i_skip = 0;
        for (t = 0; t < 400 && (exq.size() > 0 || pend || pend2); t++)
            @(negedge i_sys_clk);
        if (t == 400) fail_count++;
        test_done();
    end
endmodule : instr_fetch_data_map_bench
